// ==== design/adc_ctrl_cfg.svh ====
// constants for the converter control block: register offsets, field positions,
// reset values and clock division figures.
// assumes an 8-bit special function register address space.
`ifndef ADC_CTRL_CFG_SVH
`define ADC_CTRL_CFG_SVH

// register offsets
`define OFS_SYSTEM_CONTROL      8'hC0
`define OFS_RESULT_HIGH_BYTE    8'hCE
`define OFS_RESULT_LOW_BITS     8'hCF
`define OFS_CONVERTER_CONTROL   8'hD8
`define OFS_INPUT_SOURCE_SELECT 8'hDA
`define OFS_ANALOG_PIN_EN_LOW   8'hDC
`define OFS_ANALOG_PIN_EN_HIGH  8'hDD
`define OFS_REFERENCE_SELECT    8'hDE

// reset values
`define RST_INPUT_SOURCE_SELECT 8'h00
`define RST_ANALOG_PIN_EN_LOW   8'h00
`define RST_ANALOG_PIN_EN_HIGH  8'h00
`define RST_REFERENCE_SELECT    4'h4
`define RST_CLOCK_SELECT        2'h0

// converter_control fields
`define CC_READY_BIT            0
`define CC_MODE_BIT             1
`define CC_START_BIT            2
`define CC_RESTART_BIT          3
`define CC_CLK_SEL_LSB          6

// input_source_select fields
`define SRC_CODE_LSB            0
`define SRC_SHIFT_ENABLE_BIT    5
`define SRC_SHIFT_AMOUNT_LSB    6
`define SRC_BANDGAP_BIT         4

// reference_select codes
`define REF_EXTERNAL            4'hA
`define REF_INTERNAL_OUT        4'hB
`define REF_SUPPLY              4'h4

// converter clock divisors per clock select code
`define DIV_SEL0                7'd16
`define DIV_SEL1                7'd32
`define DIV_SEL2                7'd64
`define DIV_SEL3                7'd8
`define CONV_CLKS_PER_SAMPLE    5'd16

`endif

// ==== design/adc_ctrl_pkg.sv ====
// types shared by the converter control block.
// assumes nothing of its surroundings.
package adc_ctrl_pkg;
  typedef enum logic [0:0] {ST_IDLE, ST_RUN} conv_state_t;
  typedef logic [1:0] clk_sel_t;
endpackage : adc_ctrl_pkg

// ==== design/conv_clock_divider.sv ====
// converter clock divider producing a one-cycle enable pulse.
// assumes a single system clock and a synchronous reset.
`timescale 1ns/100ps
`default_nettype none
`include "adc_ctrl_cfg.svh"
module conv_clock_divider
  import adc_ctrl_pkg::*;
#(
  parameter int CNT_W = 7
)
(
  input  wire logic              clk_i,
  input  wire logic              reset_i,
  input  wire logic              run_i,
  input  wire adc_ctrl_pkg::clk_sel_t sel_i,
  output logic                   tick_o
);
  if (CNT_W < 7)
  begin : g_cnt_w_check
    $error("CNT_W too small for divide by 64");
  end

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic [CNT_W-1:0] div_last;

  // ----------------------------------------------------------------
  // divisor select
  // ----------------------------------------------------------------
  always_comb
  begin
    unique case (sel_i)
      2'h0: div_last = CNT_W'(`DIV_SEL0 - 7'd1); // RQ1
      2'h1: div_last = CNT_W'(`DIV_SEL1 - 7'd1); // RQ1
      2'h2: div_last = CNT_W'(`DIV_SEL2 - 7'd1); // RQ1
      2'h3: div_last = CNT_W'(`DIV_SEL3 - 7'd1); // RQ1
    endcase
  end

  always_comb
  begin
    tick_o  = 1'b0;
    cnt_nxt = cnt_r;
    if (!run_i)
      cnt_nxt = '0;
    else if (cnt_r >= div_last)
    begin
      cnt_nxt = '0;
      tick_o  = 1'b1;
    end
    else
      cnt_nxt = cnt_r + CNT_W'(1);
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      cnt_r <= '0;
    else
      cnt_r <= cnt_nxt;
  end
endmodule : conv_clock_divider
`default_nettype wire

// ==== design/adc_control.sv ====
// converter control and result registers on the special function register port.
// assumes the analog converter presents its 10-bit result on conv_data_i while
// converting, and that the cpu core decodes the interrupt return.
// Notes on behaviour
// RQ1: the converter clock is the system clock divided by 16, 32, 64 or 8 for select 0..3, one sample per 16 of its clocks.
// RQ2: with shift enable clear, the high result register holds result bits 9 to 2.
// RQ3: with shift enable set, the high result register holds the result shifted left by one to four places.
// RQ4: the five-bit source code routes port 1, port 0 or port 3 pins, or the band-gap when its top bit is set.
// RQ5: each bit of the low analog pin enable register makes the matching port 1 pin analog.
// RQ6: the high analog pin enable register makes port 0 pins 0,1 and port 3 pins 2..7 analog.
// RQ7: reference select 0xA takes the external reference, 0xB drives the internal one out, 0x4 uses the supply.
// RQ8: software writes only those three reference codes.
// RQ9: the high result register is read-only and shows eight bits chosen by the alignment controls.
// RQ10: the low result register is read-only with the two lowest result bits in bits 7 and 6.
// RQ11: the ready flag sets on new data and clears by a written zero or an interrupt return.
// RQ12: mode 0 converts continuously and mode 1 converts once per start.
// RQ13: in one-shot mode a start write begins one conversion and a restart write aborts it.
// RQ14: the converter runs only while its enable bit in system control is set.
// RQ15: both result registers and the ready flag change in the same cycle.
`timescale 1ns/100ps
`default_nettype none
`include "adc_ctrl_cfg.svh"
module adc_control
(
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic [7:0]  sfr_addr_i,
  input  wire logic        sfr_wr_i,
  input  wire logic [7:0]  sfr_wdata_i,
  output logic      [7:0]  sfr_rdata_o,
  output logic             sfr_hit_o,
  input  wire logic        converter_enable_i,
  input  wire logic        irq_return_i,
  input  wire logic [9:0]  conv_data_i,
  output logic             conv_tick_o,
  output logic             converting_o,
  output logic             ready_o,
  output logic      [4:0]  source_code_o,
  output logic             bandgap_sel_o,
  output logic      [15:0] analog_pin_o,
  output logic             ref_external_o,
  output logic             ref_drive_out_o,
  output logic             ref_supply_o
);
  import adc_ctrl_pkg::*;

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  conv_state_t state_r, state_nxt;
  logic [3:0]  samp_cnt_r, samp_cnt_nxt;
  logic [9:0]  result_r, result_nxt;
  logic        ready_r, ready_nxt;
  logic        mode_r, mode_nxt;
  clk_sel_t    clk_sel_r, clk_sel_nxt;
  logic [7:0]  src_r, src_nxt;
  logic [7:0]  pin_lo_r, pin_lo_nxt;
  logic [7:0]  pin_hi_r, pin_hi_nxt;
  logic [3:0]  ref_r, ref_nxt;
  logic [7:0]  rdata_r, rdata_nxt;
  logic        done;
  logic        tick;
  logic        wr_ctrl;
  logic [7:0]  high_byte;
  logic [13:0] wide;

  assign wr_ctrl = sfr_wr_i && (sfr_addr_i == `OFS_CONVERTER_CONTROL);

  conv_clock_divider #(.CNT_W(7)) u_div
  (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .run_i   (state_r == ST_RUN),
    .sel_i   (clk_sel_r),
    .tick_o  (tick)
  );

  // ----------------------------------------------------------------
  // result alignment
  // ----------------------------------------------------------------
  always_comb
  begin
    wide = {result_r, 4'h0};
    if (!src_r[`SRC_SHIFT_ENABLE_BIT])
      high_byte = result_r[9:2]; // RQ2
    else
    begin
      unique case (src_r[`SRC_SHIFT_AMOUNT_LSB +: 2]) // RQ3
        2'h0: high_byte = wide[12:5];
        2'h1: high_byte = wide[11:4];
        2'h2: high_byte = wide[10:3];
        2'h3: high_byte = wide[9:2];
      endcase
    end
  end

  // ----------------------------------------------------------------
  // conversion sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    state_nxt    = state_r;
    samp_cnt_nxt = samp_cnt_r;
    done         = 1'b0;
    if (!converter_enable_i)
    begin
      state_nxt    = ST_IDLE; // RQ14
      samp_cnt_nxt = '0;
    end
    else if (wr_ctrl && sfr_wdata_i[`CC_RESTART_BIT] && mode_nxt)
    begin
      state_nxt    = ST_IDLE; // RQ13
      samp_cnt_nxt = '0;
    end
    else
    begin
      unique case (state_r)
        ST_IDLE:
        begin
          samp_cnt_nxt = '0;
          if (!mode_r)
            state_nxt = ST_RUN; // RQ12
          else if (wr_ctrl && sfr_wdata_i[`CC_START_BIT] && mode_nxt)
            state_nxt = ST_RUN; // RQ13
        end
        ST_RUN:
        begin
          if (tick)
          begin
            if (samp_cnt_r == 4'(`CONV_CLKS_PER_SAMPLE - 5'd1)) // RQ1
            begin
              done         = 1'b1;
              samp_cnt_nxt = '0;
              if (mode_r)
                state_nxt = ST_IDLE; // RQ12
            end
            else
              samp_cnt_nxt = samp_cnt_r + 4'h1;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // register writes and read data
  // ----------------------------------------------------------------
  always_comb
  begin
    mode_nxt    = mode_r;
    clk_sel_nxt = clk_sel_r;
    src_nxt     = src_r;
    pin_lo_nxt  = pin_lo_r;
    pin_hi_nxt  = pin_hi_r;
    ref_nxt     = ref_r;
    ready_nxt   = ready_r;
    result_nxt  = result_r;
    if (sfr_wr_i)
    begin
      unique case (sfr_addr_i)
        `OFS_CONVERTER_CONTROL:
        begin
          mode_nxt    = sfr_wdata_i[`CC_MODE_BIT];
          clk_sel_nxt = sfr_wdata_i[`CC_CLK_SEL_LSB +: 2];
          if (!sfr_wdata_i[`CC_READY_BIT])
            ready_nxt = 1'b0; // RQ11
        end
        `OFS_INPUT_SOURCE_SELECT: src_nxt    = sfr_wdata_i;
        `OFS_ANALOG_PIN_EN_LOW:   pin_lo_nxt = sfr_wdata_i;
        `OFS_ANALOG_PIN_EN_HIGH:  pin_hi_nxt = sfr_wdata_i;
        `OFS_REFERENCE_SELECT:    ref_nxt    = sfr_wdata_i[3:0];
        default: ;
      endcase
    end
    if (irq_return_i)
      ready_nxt = 1'b0; // RQ11
    if (done)
    begin
      result_nxt = conv_data_i; // RQ15
      ready_nxt  = 1'b1;        // RQ11
    end
  end

  always_comb
  begin
    sfr_hit_o = 1'b1;
    rdata_nxt = 8'h00;
    unique case (sfr_addr_i)
      `OFS_RESULT_HIGH_BYTE:    rdata_nxt = high_byte;             // RQ9
      `OFS_RESULT_LOW_BITS:     rdata_nxt = {result_r[1:0], 6'h00}; // RQ10
      `OFS_CONVERTER_CONTROL:   rdata_nxt = {clk_sel_r, 4'h0, mode_r, ready_r};
      `OFS_INPUT_SOURCE_SELECT: rdata_nxt = src_r;
      `OFS_ANALOG_PIN_EN_LOW:   rdata_nxt = pin_lo_r;
      `OFS_ANALOG_PIN_EN_HIGH:  rdata_nxt = pin_hi_r;
      `OFS_REFERENCE_SELECT:    rdata_nxt = {4'h0, ref_r};
      default:                  sfr_hit_o = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      state_r    <= ST_IDLE;
      samp_cnt_r <= '0;
      result_r   <= '0;
      ready_r    <= 1'b0;
      mode_r     <= 1'b0;
      clk_sel_r  <= `RST_CLOCK_SELECT;
      src_r      <= `RST_INPUT_SOURCE_SELECT;
      pin_lo_r   <= `RST_ANALOG_PIN_EN_LOW;
      pin_hi_r   <= `RST_ANALOG_PIN_EN_HIGH;
      ref_r      <= `RST_REFERENCE_SELECT;
      rdata_r    <= 8'h00;
    end
    else
    begin
      state_r    <= state_nxt;
      samp_cnt_r <= samp_cnt_nxt;
      result_r   <= result_nxt;
      ready_r    <= ready_nxt;
      mode_r     <= mode_nxt;
      clk_sel_r  <= clk_sel_nxt;
      src_r      <= src_nxt;
      pin_lo_r   <= pin_lo_nxt;
      pin_hi_r   <= pin_hi_nxt;
      ref_r      <= ref_nxt;
      rdata_r    <= rdata_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs to the analog side
  // ----------------------------------------------------------------
  assign sfr_rdata_o     = rdata_r;
  assign conv_tick_o     = tick;
  assign converting_o    = (state_r == ST_RUN);
  assign ready_o         = ready_r;
  assign source_code_o   = src_r[`SRC_CODE_LSB +: 5];  // RQ4
  assign bandgap_sel_o   = src_r[`SRC_BANDGAP_BIT];    // RQ4
  assign analog_pin_o    = {pin_hi_r, pin_lo_r};       // RQ5 RQ6
  assign ref_external_o  = (ref_r == `REF_EXTERNAL);   // RQ7
  assign ref_drive_out_o = (ref_r == `REF_INTERNAL_OUT); // RQ7
  assign ref_supply_o    = (ref_r == `REF_SUPPLY);     // RQ7

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  sequence s_last_tick;
    converting_o && tick && samp_cnt_r == 4'hF;
  endsequence

  a_ready_on_done: assert property ((s_last_tick and (converter_enable_i && !wr_ctrl)) |=> ready_r) // RQ11
    else $error("ready flag not set after a completed sample");
  a_ready_sw_clear: assert property (wr_ctrl && !sfr_wdata_i[0] && !done |=> !ready_r) // RQ11
    else $error("written zero did not clear ready");
  a_ready_reti: assert property (irq_return_i && !done |=> !ready_r) // RQ11
    else $error("interrupt return did not clear ready");
  a_results_together: assert property ($rose(ready_r) |-> result_r == $past(conv_data_i)) // RQ15
    else $error("result not captured with ready");
  a_low_bits_read: assert property (sfr_addr_i == 8'hCF && !done |=> sfr_rdata_o == {result_r[1:0], 6'h00}) // RQ10
    else $error("low result register layout wrong");
  a_high_plain: assert property (sfr_addr_i == 8'hCE && !src_r[5] && !done
                                 |=> sfr_rdata_o == result_r[9:2]) // RQ2
    else $error("unshifted high byte wrong");
  a_high_shift4: assert property (sfr_addr_i == 8'hCE && src_r[7:5] == 3'b111 && !done
                                  |=> sfr_rdata_o == {result_r[5:0], 2'b00}) // RQ3
    else $error("four-place shift wrong");
  a_disable_stop: assert property (!converter_enable_i |=> !converting_o) // RQ14
    else $error("converter runs while disabled");
  a_oneshot_end: assert property ((s_last_tick and (mode_r && !wr_ctrl)) |=> !converting_o) // RQ12
    else $error("one-shot did not stop after one sample");
  a_restart_abort: assert property (wr_ctrl && sfr_wdata_i[3] && sfr_wdata_i[1] |=> !converting_o) // RQ13
    else $error("restart write did not abort");
  a_sample_spacing: assert property ((s_last_tick and (!mode_r && converter_enable_i && !wr_ctrl))
                                     |=> ready_r && converting_o && samp_cnt_r == 4'h0) // RQ1
    else $error("sample counter did not wrap");
  a_ref_decode: assert property (sfr_wr_i && sfr_addr_i == 8'hDE && sfr_wdata_i[3:0] == 4'hB
                                 |=> ref_drive_out_o && !ref_external_o && !ref_supply_o) // RQ7
    else $error("reference decode not exclusive");
endmodule : adc_control
`default_nettype wire

// ==== sim/adc_control_test.sv ====
// self-checking bench for adc_control: register access, routing, references, conversions.
// assumes the design files are compiled first; the bench drives every port itself.
`timescale 1ns/100ps
`default_nettype none
module adc_control_test;
  logic        clk_i;
  logic        reset_i;
  logic        sfr_wr_i;
  logic        converter_enable_i;
  logic        irq_return_i;
  logic [7:0]  sfr_addr_i;
  logic [7:0]  sfr_wdata_i;
  logic [7:0]  sfr_rdata_o;
  logic [9:0]  conv_data_i;
  logic [4:0]  source_code_o;
  logic [15:0] analog_pin_o;
  logic        sfr_hit_o;
  logic        conv_tick_o;
  logic        converting_o;
  logic        ready_o;
  logic        bandgap_sel_o;
  logic        ref_external_o;
  logic        ref_drive_out_o;
  logic        ref_supply_o;
  int          fail_count;
  int          checks_done;
  int          cycles;
  int          n;
  int          dv[4] = '{16, 32, 64, 8};
  logic [3:0]  refs[3] = '{4'hA, 4'hB, 4'h4};
  logic [9:0]  res;

  adc_control dut (
    .clk_i(clk_i), .reset_i(reset_i), .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i),
    .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o), .sfr_hit_o(sfr_hit_o),
    .converter_enable_i(converter_enable_i), .irq_return_i(irq_return_i),
    .conv_data_i(conv_data_i), .conv_tick_o(conv_tick_o), .converting_o(converting_o),
    .ready_o(ready_o), .source_code_o(source_code_o), .bandgap_sel_o(bandgap_sel_o),
    .analog_pin_o(analog_pin_o), .ref_external_o(ref_external_o),
    .ref_drive_out_o(ref_drive_out_o), .ref_supply_o(ref_supply_o));

  // ---------------------------------------------------------------
  // clock and hang guard
  // ---------------------------------------------------------------
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 8000)
    begin
      fail_count++;
      conclude();
    end
  end

  // ---------------------------------------------------------------
  // access tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    sfr_addr_i  <= a;
    sfr_wdata_i <= d;
    sfr_wr_i    <= 1'b1;
    @(posedge clk_i);
    sfr_wr_i <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic h);
    @(posedge clk_i);
    sfr_addr_i <= a;
    @(posedge clk_i);
    #1;
    chk(sfr_rdata_o, e);
    chk(sfr_hit_o, h);
  endtask : rd

  // counts cycles from the start of a run until ready rises
  task automatic conv(input int d, input logic run);
    int t;
    t = 0;
    n = 0;
    while (converting_o !== 1'b1 && n < 10)
    begin
      @(posedge clk_i);
      #1;
      n++;
    end
    n = 0;
    while (ready_o !== 1'b1 && n < 2000)
    begin
      @(posedge clk_i);
      #1;
      n++;
      if (conv_tick_o === 1'b1)
        t++;
    end
    chk(16'(n), 16'(16 * d));
    chk(16'(t), 16'd16);
    chk(converting_o, run);
  endtask : conv

  task automatic conclude;
    if (fail_count == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : conclude

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    reset_i = 1'b1;
    sfr_wr_i = 1'b0;
    sfr_addr_i = 8'h00;
    sfr_wdata_i = 8'h00;
    converter_enable_i = 1'b0;
    irq_return_i = 1'b0;
    conv_data_i = 10'h000;
    repeat (6) @(posedge clk_i);
    reset_i <= 1'b0;
    rd(8'hDA, 8'h00, 1'b1);
    rd(8'hDC, 8'h00, 1'b1);
    rd(8'hDE, 8'h04, 1'b1);
    rd(8'hD8, 8'h00, 1'b1);
    rd(8'hD0, 8'h00, 1'b0);
    chk(ref_supply_o, 1'b1);
    for (int c = 0; c < 32; c += 3)
    begin
      wr(8'hDA, 8'(c));
      chk({bandgap_sel_o, source_code_o}, 16'({c[4], c[4:0]}));
    end
    wr(8'hDC, 8'hA5);
    wr(8'hDD, 8'h3C);
    chk(analog_pin_o, 16'h3CA5);
    rd(8'hDD, 8'h3C, 1'b1);
    foreach (refs[i])
    begin
      wr(8'hDE, {4'h0, refs[i]});
      chk({ref_external_o, ref_drive_out_o, ref_supply_o}, {i == 0, i == 1, i == 2});
    end
    wr(8'hDA, 8'h00);
    wr(8'hCE, 8'hFF);
    wr(8'hCF, 8'hFF);
    rd(8'hCE, 8'h00, 1'b1);
    rd(8'hCF, 8'h00, 1'b1);
    // one-shot conversions at every clock select
    wr(8'hD8, 8'h02);
    @(posedge clk_i);
    converter_enable_i <= 1'b1;
    for (int s = 0; s < 4; s++)
    begin
      res = 10'h2D6 + 10'(s * 10'h0A7);
      @(posedge clk_i);
      conv_data_i <= res;
      wr(8'hD8, {2'(s), 6'h06});
      conv(dv[s], 1'b0);
      rd(8'hCE, res[9:2], 1'b1);
      rd(8'hCF, {res[1:0], 6'h00}, 1'b1);
    end
    rd(8'hD8, 8'hC3, 1'b1);
    for (int a = 0; a < 4; a++)
    begin
      wr(8'hDA, {2'(a), 1'b1, 5'h00});
      rd(8'hCE, 8'((res << (a + 1)) >> 2), 1'b1);
    end
    // ready: a written one keeps it, interrupt return and written zero clear it
    wr(8'hD8, 8'hC3);
    chk(ready_o, 1'b1);
    @(posedge clk_i);
    irq_return_i <= 1'b1;
    @(posedge clk_i);
    irq_return_i <= 1'b0;
    @(posedge clk_i);
    #1;
    chk(ready_o, 1'b0);
    wr(8'hD8, 8'hC6);
    conv(8, 1'b0);
    wr(8'hD8, 8'hC2);
    chk(ready_o, 1'b0);
    // abort a one-shot run in mid-count
    wr(8'hD8, 8'h06);
    repeat (20) @(posedge clk_i);
    wr(8'hD8, 8'h0A);
    chk(converting_o, 1'b0);
    repeat (300) @(posedge clk_i);
    #1;
    chk(ready_o, 1'b0);
    // enable low stops a run, then continuous mode repeats
    wr(8'hD8, 8'h06);
    repeat (20) @(posedge clk_i);
    converter_enable_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
    chk(converting_o, 1'b0);
    wr(8'hD8, 8'hC0);
    repeat (4) @(posedge clk_i);
    #1;
    chk(converting_o, 1'b0);
    @(posedge clk_i);
    converter_enable_i <= 1'b1;
    conv(8, 1'b1);
    wr(8'hD8, 8'hC0);
    repeat (16 * 8 + 4) @(posedge clk_i);
    #1;
    chk(ready_o, 1'b1);
    conclude();
  end
endmodule : adc_control_test
`default_nettype wire
